// [rtl/swif_consts.vh]
`ifndef SWIF_CONSTS_VH
`define SWIF_CONSTS_VH
// ==========================================================
// register word offsets (byte addresses)
`define SWIF_OFS_FLAGS_1      12'h000
`define SWIF_OFS_FLAGS_2      12'h004
`define SWIF_OFS_FLAGS_3      12'h008
`define SWIF_OFS_ENABLES_1    12'h00C
`define SWIF_OFS_ENABLES_2    12'h010
`define SWIF_OFS_ENABLES_3    12'h014
`define SWIF_OFS_IRQ_CONTROL  12'h018
`define SWIF_OFS_REG_CONTROL  12'h01C
`define SWIF_OFS_STATUS       12'h020
`define SWIF_OFS_CONFIG       12'h024
// ==========================================================
// implemented-bit masks and reset values
`define SWIF_MASK_FLAGS_1     8'hFF
`define SWIF_MASK_FLAGS_2     8'hEF
`define SWIF_MASK_FLAGS_3     8'h7F
`define SWIF_RST_FLAGS        8'h00
`define SWIF_RST_ENABLES      8'h00
`define SWIF_RST_IRQ_CONTROL  8'h00
`define SWIF_RST_REG_CONTROL  8'h01
// ==========================================================
// field positions
`define SWIF_BIT_GIE          7
`define SWIF_BIT_PERIPHERAL_IRQ_GATE         6
`define SWIF_BIT_LOWPOWER     1
`define SWIF_BIT_REG_RSVD     0
`define SWIF_BIT_EXPIRY       4
`define SWIF_BIT_PWRDN        3
`define SWIF_BIT_CFG_CRYSTAL  0
`define SWIF_BIT_CFG_WDT_SLP  1
// ==========================================================
// timing
`define SWIF_OST_PERIODS      1024
`endif

// [rtl/swif_sleep_wake.v]
// How it works
// - flags set on events regardless of enables
// - flags two: clock fail to capture two
// - flags three: bit7 zero, osc to cells
// - one pending, software writable, reset zero
// - power-down entered only by sleep instruction
// - entry clears power-down, sets expiry, gates clock
// - entry clears watchdog, runs if sleep-enabled
// - slow oscillator domain keeps running asleep
// - pins hold their pre-sleep drive state
// - non-watchdog resets unchanged by sleep
// - hard resets reset; others resume execution
// - enabled event wakes, ignoring global enable
// - global enable set vectors after next instruction
// - next instruction prefetched during sleep
// - watchdog cleared on every wake
// - pending enabled flag makes sleep a no-op
// - flag during sleep: complete then wake
// - crystal wake waits 1024 oscillator periods
// - low-power select lowers regulator while asleep
// - peripheral irq also needs peripheral gate
// - low-power select reads back, resets zero
// - watchdog timeout asleep wakes, no reset
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "swif_consts.vh"
module swif_sleep_wake #(
   parameter OST_PERIODS = `SWIF_OST_PERIODS
)(
   // apb slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // peripheral event pulses, one bit per flag position
   input  wire [7:0]  event_set_1,
   input  wire [7:0]  event_set_2,
   input  wire [7:0]  event_set_3,
   // core side
   input  wire        sleep_exec,
   input  wire        clrwdt_exec,
   input  wire        osc_tick,
   input  wire        wdt_timeout,
   input  wire        osc_fail,
   output reg         core_clk_en,
   output reg         prefetch_next,
   output reg         isr_vector_req,
   output reg         asleep,
   output reg         wdt_clear,
   output reg         wdt_run_in_sleep,
   output reg         regulator_lowpower,
   output reg         pin_hold,
   output reg         peripheral_irq
);
   // ==========================================================
   // state machine
   localparam [1:0] ST_AWAKE = 2'b00;
   localparam [1:0] ST_SLEEP = 2'b01;
   localparam [1:0] ST_OST   = 2'b10;
   localparam [1:0] ST_RESUM = 2'b11;
   localparam CNT_W = 11;

   reg  [7:0]       flags_1;
   reg  [7:0]       flags_2;
   reg  [7:0]       flags_3;
   reg  [7:0]       enables_1;
   reg  [7:0]       enables_2;
   reg  [7:0]       enables_3;
   reg  [7:0]       irq_control_reg;
   reg  [7:0]       regulator_control_reg;
   reg              power_down_status;
   reg              watchdog_expiry_status;
   reg  [1:0]       cfg;
   reg  [1:0]       state;
   reg  [CNT_W-1:0] ost_cnt;
   wire             wr_acc;
   wire             rd_acc;
   wire             wake_req;
   wire             any_enabled;
   wire [7:0]       wdata8;
   reg  [31:0]      next_prdata;
   reg              next_err;

   // pending and enabled term per register
   function pend;
      input [7:0] f;
      input [7:0] e;
      begin
         pend = |(f & e);
      end
   endfunction

   // a write lands only at the edge where the master sees pready high
   assign wr_acc = psel & penable & pwrite & pready;
   assign rd_acc = psel & penable & ~pwrite & ~pready;
   assign wdata8 = pwdata[7:0];
   // enabled pending peripheral flag wakes, global enable not involved
   assign any_enabled = pend(flags_1, enables_1) | pend(flags_2, enables_2)
                      | pend(flags_3, enables_3);
   assign wake_req = any_enabled | (wdt_timeout & cfg[`SWIF_BIT_CFG_WDT_SLP]);

   // ==========================================================
   // flag registers, set wins over a software write
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_1 <= `SWIF_RST_FLAGS;
         flags_2 <= `SWIF_RST_FLAGS;
         flags_3 <= `SWIF_RST_FLAGS;
      end
      else
      begin
         if (wr_acc && paddr == `SWIF_OFS_FLAGS_1)
            flags_1 <= (wdata8 | event_set_1) & `SWIF_MASK_FLAGS_1;
         else
            flags_1 <= flags_1 | (event_set_1 & `SWIF_MASK_FLAGS_1);
         if (wr_acc && paddr == `SWIF_OFS_FLAGS_2)
            flags_2 <= (wdata8 | event_set_2) & `SWIF_MASK_FLAGS_2;
         else
            flags_2 <= flags_2 | (event_set_2 & `SWIF_MASK_FLAGS_2);
         if (wr_acc && paddr == `SWIF_OFS_FLAGS_3)
            flags_3 <= (wdata8 | event_set_3) & `SWIF_MASK_FLAGS_3;
         else
            flags_3 <= flags_3 | (event_set_3 & `SWIF_MASK_FLAGS_3);
      end
   end

   // ==========================================================
   // enable, control and config registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enables_1             <= `SWIF_RST_ENABLES;
         enables_2             <= `SWIF_RST_ENABLES;
         enables_3             <= `SWIF_RST_ENABLES;
         irq_control_reg       <= `SWIF_RST_IRQ_CONTROL;
         regulator_control_reg <= `SWIF_RST_REG_CONTROL;
         cfg                   <= 2'h0;
      end
      else if (wr_acc)
      begin
         case (paddr)
            `SWIF_OFS_ENABLES_1:   enables_1 <= wdata8 & `SWIF_MASK_FLAGS_1;
            `SWIF_OFS_ENABLES_2:   enables_2 <= wdata8 & `SWIF_MASK_FLAGS_2;
            `SWIF_OFS_ENABLES_3:   enables_3 <= wdata8 & `SWIF_MASK_FLAGS_3;
            `SWIF_OFS_IRQ_CONTROL: irq_control_reg <= wdata8;
            `SWIF_OFS_REG_CONTROL: regulator_control_reg <= {6'h00, wdata8[`SWIF_BIT_LOWPOWER], 1'b1};
            `SWIF_OFS_CONFIG:      cfg <= wdata8[1:0];
            default:               cfg <= cfg;
         endcase
      end
   end

   // ==========================================================
   // read mux and error decode
   always @*
   begin
      next_prdata = 32'h0000_0000;
      next_err    = 1'b0;
      case (paddr)
         `SWIF_OFS_FLAGS_1:     next_prdata[7:0] = flags_1;
         `SWIF_OFS_FLAGS_2:     next_prdata[7:0] = flags_2;
         `SWIF_OFS_FLAGS_3:     next_prdata[7:0] = flags_3;
         `SWIF_OFS_ENABLES_1:   next_prdata[7:0] = enables_1;
         `SWIF_OFS_ENABLES_2:   next_prdata[7:0] = enables_2;
         `SWIF_OFS_ENABLES_3:   next_prdata[7:0] = enables_3;
         `SWIF_OFS_IRQ_CONTROL: next_prdata[7:0] = irq_control_reg;
         `SWIF_OFS_REG_CONTROL: next_prdata[7:0] = regulator_control_reg;
         `SWIF_OFS_STATUS:      next_prdata[7:0] = {3'h0, watchdog_expiry_status, power_down_status, 3'h0};
         `SWIF_OFS_CONFIG:      next_prdata[7:0] = {6'h00, cfg};
         default:               next_err = 1'b1;
      endcase
   end

   // apb answer: ready one cycle after access phase starts
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & next_err;
         if (rd_acc)
            prdata <= next_prdata;
      end
   end

   // ==========================================================
   // sleep sequencer; hard resets arrive on presetn in any state
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state                  <= ST_AWAKE;
         ost_cnt                <= {CNT_W{1'b0}};
         power_down_status      <= 1'b1;
         watchdog_expiry_status <= 1'b1;
         core_clk_en            <= 1'b1;
         prefetch_next          <= 1'b0;
         isr_vector_req         <= 1'b0;
         asleep                 <= 1'b0;
         wdt_clear              <= 1'b1;
         wdt_run_in_sleep       <= 1'b0;
         regulator_lowpower     <= 1'b0;
         pin_hold               <= 1'b0;
      end
      else
      begin
         prefetch_next  <= 1'b0;
         isr_vector_req <= 1'b0;
         wdt_clear      <= clrwdt_exec | osc_fail;
         case (state)
            ST_AWAKE:
            begin
               if (sleep_exec)
               begin
                  prefetch_next <= 1'b1;
                  if (!any_enabled)
                  begin
                     state                  <= ST_SLEEP;
                     power_down_status      <= 1'b0;
                     watchdog_expiry_status <= 1'b1;
                     core_clk_en            <= 1'b0;
                     asleep                 <= 1'b1;
                     pin_hold               <= 1'b1;
                     wdt_clear              <= 1'b1;
                     wdt_run_in_sleep       <= cfg[`SWIF_BIT_CFG_WDT_SLP];
                     regulator_lowpower     <= regulator_control_reg[`SWIF_BIT_LOWPOWER];
                  end
               end
            end
            ST_SLEEP:
            begin
               if (wake_req)
               begin
                  wdt_clear          <= 1'b1;
                  regulator_lowpower <= 1'b0;
                  wdt_run_in_sleep   <= 1'b0;
                  ost_cnt            <= {CNT_W{1'b0}};
                  if (wdt_timeout && !any_enabled)
                     watchdog_expiry_status <= 1'b0;
                  state <= cfg[`SWIF_BIT_CFG_CRYSTAL] ? ST_OST : ST_RESUM;
               end
            end
            ST_OST:
            begin
               wdt_clear <= 1'b1;
               if (osc_tick)
               begin
                  if (ost_cnt == OST_PERIODS - 1)
                     state <= ST_RESUM;
                  else
                     ost_cnt <= ost_cnt + 1'b1;
               end
            end
            ST_RESUM:
            begin
               state       <= ST_AWAKE;
               core_clk_en <= 1'b1;
               asleep      <= 1'b0;
               pin_hold    <= 1'b0;
               isr_vector_req <= irq_control_reg[`SWIF_BIT_GIE] & irq_control_reg[`SWIF_BIT_PERIPHERAL_IRQ_GATE]
                               & any_enabled;
            end
            default: state <= ST_AWAKE;
         endcase
      end
   end

   // peripheral request to core, gated by peripheral gate bit
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         peripheral_irq <= 1'b0;
      else
         peripheral_irq <= any_enabled & irq_control_reg[`SWIF_BIT_PERIPHERAL_IRQ_GATE];
   end
endmodule // swif_sleep_wake

// [verif/swif_sva.sv]
`timescale 1ns/1ps
// ==========================================
// checker for bus and sleep behaviour
module swif_sva #(
   parameter OST_PERIODS = 1024
)(
   // clock and reset
   input logic pclk,
   input logic presetn,
   // bus
   input logic psel,
   input logic penable,
   input logic pready,
   input logic pslverr,
   // sleep control
   input logic sleep_exec,
   input logic asleep,
   input logic core_clk_en,
   input logic prefetch_next,
   input logic wdt_clear,
   input logic pin_hold
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_rdy_pulse: assert property (pready |=> !pready)
      else $error("pready held over one cycle");
   a_rdy_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("pready not one cycle after access");
   a_err_rdy: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_prefetch_next: assert property (sleep_exec && !asleep |-> ##[0:1] prefetch_next)
      else $error("no prefetch on sleep");
   a_sleep_cause: assert property ($rose(asleep) |-> $past(sleep_exec))
      else $error("sleep entered without sleep instruction");
   a_entry_wdt: assert property ($rose(asleep) |-> wdt_clear && !core_clk_en)
      else $error("entry did not clear watchdog");
   a_gate_clk: assert property (asleep |-> !core_clk_en && pin_hold)
      else $error("core clock or pins not held asleep");
   a_wake_wdt: assert property ($fell(asleep) |-> $past(wdt_clear))
      else $error("wake did not clear watchdog");
endmodule // swif_sva

// [verif/swif_core_model.sv]
`timescale 1ns/1ps
// ==========================================
// core and slow oscillator stand-in
module swif_core_model (
   // clock and reset
   input  logic pclk,
   input  logic presetn,
   // bench request
   input  logic sleep_req,
   // to the block
   output logic sleep_exec,
   output logic osc_tick
);
   logic [1:0] div;
   // sleep pulse per request, slow tick every third cycle
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sleep_exec <= 1'b0;
         osc_tick   <= 1'b0;
         div        <= 2'h0;
      end
      else
      begin
         sleep_exec <= sleep_req;
         div        <= (div == 2'h2) ? 2'h0 : div + 2'h1;
         osc_tick   <= (div == 2'h2);
      end
endmodule // swif_core_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
// ==========================================
// testbench
module tb_top;
   localparam CRYSTAL_STARTUP_TIMER = 4;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [7:0]  ev1, ev2, ev3;
   logic        sleep_req, sleep_exec, osc_tick, wdt_to, core_clk_en, prefetch_next;
   logic        isr_vector_req, asleep, wdt_clear, wdt_run, reg_lp, pin_hold, per_irq;
   int          failures, checked, cyc, vec_n, n;
   integer      seed = 32'hC8C5A664;
   int          sh[10];
   int          msk[10] = '{8'hFF, 8'hEF, 8'h7F, 8'hFF, 8'hEF, 8'h7F, 8'hC0, 8'h02, 8'h00, 8'h03};
   swif_sleep_wake #(.OST_PERIODS(CRYSTAL_STARTUP_TIMER)) swif_sleep_wake_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_set_1(ev1), .event_set_2(ev2), .event_set_3(ev3), .sleep_exec(sleep_exec),
      .clrwdt_exec(1'b0), .osc_tick(osc_tick), .wdt_timeout(wdt_to), .osc_fail(1'b0),
      .core_clk_en(core_clk_en), .prefetch_next(prefetch_next), .isr_vector_req(isr_vector_req),
      .asleep(asleep), .wdt_clear(wdt_clear), .wdt_run_in_sleep(wdt_run),
      .regulator_lowpower(reg_lp), .pin_hold(pin_hold), .peripheral_irq(per_irq));
   swif_core_model swif_core_model_inst (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req),
      .sleep_exec(sleep_exec), .osc_tick(osc_tick));
   // clock
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // vector pulse count and hang limit
   always @(posedge pclk)
   begin
      cyc++;
      if (isr_vector_req === 1'b1)
         vec_n++;
      if (cyc == 20000)
      begin
         failures++;
         tally_and_finish;
      end
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd_v  = prdata;
      err_v = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input int a, input int d);
      apb(1'b1, a[11:0], d);
      if (a < 40)
         sh[a/4] = (d & msk[a/4]) | (sh[a/4] & ~msk[a/4]);
   endtask
   task rd(input int a);
      apb(1'b0, a[11:0], 32'h0);
      chk("read", rd_v, (a < 40) ? sh[a/4] : 0);
   endtask
   task ev(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      @(posedge pclk);
      ev1 <= a;
      ev2 <= b;
      ev3 <= c;
      sh[0] = sh[0] | a;
      sh[1] = sh[1] | (b & msk[1]);
      sh[2] = sh[2] | (c & msk[2]);
      @(posedge pclk);
      {ev1, ev2, ev3} <= 24'h0;
   endtask
   task slp;
      @(posedge pclk);
      sleep_req <= 1'b1;
      @(posedge pclk);
      sleep_req <= 1'b0;
   endtask
   task waitst(input logic v);
      n = 0;
      while (asleep !== v && n < 200)
      begin
         @(posedge pclk);
         n++;
      end
      chk("asleep", asleep, v);
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, ev1, ev2, ev3, sleep_req, wdt_to} = 0;
      presetn = 1'b0;
      sh = '{0, 0, 0, 0, 0, 0, 0, 8'h01, 8'h18, 0};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 11; i++) rd(i * 4);
      chk("slverr", err_v, 1'b1);
      for (int i = 0; i < 3; i++) wr(i * 4, $random(seed));
      wr(12'h01C, $random(seed));
      for (int i = 0; i < 3; i++) rd(i * 4);
      rd(12'h01C);
      for (int i = 0; i < 3; i++) wr(i * 4, 0);
      ev($random(seed), $random(seed), $random(seed));
      for (int i = 0; i < 3; i++) rd(i * 4);
      ev(8'h00, 8'h01, 8'h00);
      wr(12'h010, 1);
      slp;
      repeat (4) @(posedge pclk);
      chk("noop", asleep, 1'b0);
      rd(12'h020);
      for (int i = 0; i < 3; i++) wr(i * 4, 0);
      wr(12'h01C, 2);
      slp;
      waitst(1'b1);
      chk("clk_en", core_clk_en, 1'b0);
      chk("reg_lp", reg_lp, 1'b1);
      sh[8] = 8'h10;
      rd(12'h020);
      ev(8'h00, 8'h01, 8'h00);
      waitst(1'b0);
      chk("clk_on", core_clk_en, 1'b1);
      chk("vec0", vec_n, 0);
      wr(12'h004, 0);
      wr(12'h018, 8'hC0);
      slp;
      waitst(1'b1);
      ev(8'h00, 8'h01, 8'h00);
      waitst(1'b0);
      repeat (3) @(posedge pclk);
      chk("vec1", vec_n, 1);
      chk("per_irq", per_irq, 1'b1);
      wr(12'h018, 8'h40);
      wr(12'h010, 0);
      repeat (3) @(posedge pclk);
      chk("per_off", per_irq, 1'b0);
      wr(12'h004, 0);
      wr(12'h024, 2);
      slp;
      waitst(1'b1);
      chk("wdt_run", wdt_run, 1'b1);
      wdt_to <= 1'b1;
      @(posedge pclk);
      wdt_to <= 1'b0;
      waitst(1'b0);
      sh[8] = 8'h00;
      rd(12'h020);
      wr(12'h010, 1);
      wr(12'h024, 1);
      slp;
      waitst(1'b1);
      ev(8'h00, 8'h01, 8'h00);
      waitst(1'b0);
      chk("ost", n >= 3 * CRYSTAL_STARTUP_TIMER - 3, 1'b1);
      sh[8] = 8'h10;
      rd(12'h020);
      tally_and_finish;
   end
endmodule // tb_top
bind swif_sleep_wake swif_sva #(.OST_PERIODS(OST_PERIODS)) swif_sva_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .sleep_exec(sleep_exec), .asleep(asleep), .core_clk_en(core_clk_en),
   .prefetch_next(prefetch_next), .wdt_clear(wdt_clear), .pin_hold(pin_hold));
